// File: rtl/ricfg_consts.vh
/*
  Constants for the reference input and status pin configuration bank:
  register indices, the address bit range, field positions and reset values.
  Assumes a 32-bit AHB-Lite bus with one aligned word per register.
*/
// Function
// - Config bit 2 set powers the second reference input on, else off.
// - Config bit 1 set powers the first reference input on, else off.
// - Config bit 0 picks differential mode at 1, single-ended at 0.
// - With aux bit 7 clear the status pin shows the selected source.
// - Aux bit 7 set (reset) routes the nonvolatile status to the pin.
`ifndef RICFG_CONSTS_VH
`define RICFG_CONSTS_VH

`define RICFG_IDX_STAT_CTRL   10'h017
`define RICFG_IDX_REF_CFG     10'h01c
`define RICFG_IDX_AUX_CFG     10'h01d
`define RICFG_IDX_LSB         2
`define RICFG_IDX_MSB         11
`define RICFG_RST_IDX         10'h000
`define RICFG_RST_RDATA       32'h00000000
`define RICFG_BYTE_MSB        7
`define RICFG_BYTE_LSB        0

`define RICFG_RST_STAT_CTRL   8'h00
`define RICFG_RST_REF_CFG     8'h00
`define RICFG_RST_AUX_CFG     8'h80

`define RICFG_REF_CFG_MASK    8'he7
`define RICFG_BIT_SECOND_EN   3'h2
`define RICFG_BIT_FIRST_EN    3'h1
`define RICFG_BIT_DIFF        3'h0
`define RICFG_BIT_EEPROM_OVR  7
`define RICFG_SEL_MSB         7
`define RICFG_SEL_LSB         2

`define RICFG_HTRANS_NONSEQ_BIT 1
`define RICFG_RDATA_PAD       24'h000000
`define RICFG_ZERO_BYTE       8'h00

`endif

// File: rtl/ricfg_top.v
/*
  Register bank for the PLL reference inputs and the status pin override,
  as an AHB-Lite slave with zero wait states.
  Assumes a single master, word transfers only, and status sources that
  are synchronous to CLK.
  Assumes software keeps both reference power enables clear while
  differential mode is selected; the bank does not enforce it.
  Every output is a flip-flop; the power, mode and status outputs lag their stored bits by one clock.
*/
`timescale 1ns/1ps
`include "ricfg_consts.vh"

module ricfg_top
(
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  input  wire        EEPROM_STATUS,
  input  wire [63:0] STATUS_SOURCES,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  output reg         FIRST_REF_POWER_EN,
  output reg         SECOND_REF_POWER_EN,
  output reg         DIFF_MODE,
  output reg         STATUS_PIN
);

  reg  [7:0]  stat_ctrl_reg;
  reg  [7:0]  ref_cfg_reg;
  reg  [7:0]  aux_cfg_reg;
  reg         wr_pend_reg;
  reg  [9:0]  wr_idx_reg;
  reg  [7:0]  stat_ctrl_next;
  reg  [7:0]  ref_cfg_next;
  reg  [7:0]  aux_cfg_next;
  reg  [7:0]  rd_byte;
  wire [9:0]  addr_idx;
  wire        take;
  wire [5:0]  sel_field;
  wire [7:0]  wr_byte;

  // hsize is not checked: only word transfers are issued on this bus
  assign addr_idx  = HADDR[`RICFG_IDX_MSB:`RICFG_IDX_LSB];
  assign take      = HSEL & HREADY & HTRANS[`RICFG_HTRANS_NONSEQ_BIT];
  assign sel_field = stat_ctrl_reg[`RICFG_SEL_MSB:`RICFG_SEL_LSB];
  // only the low byte is stored; upper data bits are ignored
  assign wr_byte   = HWDATA[`RICFG_BYTE_MSB:`RICFG_BYTE_LSB];

  function [7:0] ricfg_read;
    input [9:0] idx;
    input [7:0] s;
    input [7:0] r;
    input [7:0] a;
    begin
      case (idx)
        `RICFG_IDX_STAT_CTRL: ricfg_read = s;
        `RICFG_IDX_REF_CFG:   ricfg_read = r;
        `RICFG_IDX_AUX_CFG:   ricfg_read = a;
        default:              ricfg_read = `RICFG_ZERO_BYTE;
      endcase
    end
  endfunction

  // data phase write lands here; next values also feed read forwarding
  always @*
  begin
    stat_ctrl_next = stat_ctrl_reg;
    ref_cfg_next   = ref_cfg_reg;
    aux_cfg_next   = aux_cfg_reg;
    if (wr_pend_reg)
    begin
      case (wr_idx_reg)
        `RICFG_IDX_STAT_CTRL: stat_ctrl_next = wr_byte;
        // reserved bits are dropped, they read as zero
        `RICFG_IDX_REF_CFG:
          ref_cfg_next = wr_byte & `RICFG_REF_CFG_MASK;
        `RICFG_IDX_AUX_CFG:   aux_cfg_next = wr_byte;
        default:              stat_ctrl_next = stat_ctrl_reg;
      endcase
    end
    // read after write in back-to-back phases sees the new value
    rd_byte = ricfg_read(addr_idx, stat_ctrl_next, ref_cfg_next,
                         aux_cfg_next);
  end

  // register store and write bookkeeping
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stat_ctrl_reg <= `RICFG_RST_STAT_CTRL;
      ref_cfg_reg   <= `RICFG_RST_REF_CFG;
      aux_cfg_reg   <= `RICFG_RST_AUX_CFG;
      wr_pend_reg   <= 1'b0;
      wr_idx_reg    <= `RICFG_RST_IDX;
    end
    else
    begin
      stat_ctrl_reg <= stat_ctrl_next;
      ref_cfg_reg   <= ref_cfg_next;
      aux_cfg_reg   <= aux_cfg_next;
      wr_pend_reg   <= take & HWRITE;
      if (take)
        wr_idx_reg  <= addr_idx;
    end
  end

  // zero wait states: the read byte is loaded when the address is taken,
  // so it stands through the whole data phase
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      HRDATA        <= `RICFG_RST_RDATA;
      HREADYOUT     <= 1'b1;
      HRESP         <= 1'b0;
    end
    else
    begin
      if (take & ~HWRITE)
        HRDATA      <= {`RICFG_RDATA_PAD, rd_byte};
      HREADYOUT     <= 1'b1;
      HRESP         <= 1'b0;
    end
  end

  // override wins over the select field
  function ricfg_status_pick;
    input        ovr;
    input        nv_status;
    input [63:0] sources;
    input [5:0]  sel;
    begin
      if (ovr)
      begin
        ricfg_status_pick = nv_status;
      end
      else
      begin
        ricfg_status_pick = sources[sel];
      end
    end
  endfunction

  // one control bit of a stored byte
  function ricfg_bit;
    input [7:0] value;
    input [2:0] pos;
    begin
      ricfg_bit = value[pos];
    end
  endfunction

  // power and mode outputs follow the stored bits one cycle later;
  // differential mode does not gate the enables, software keeps them clear

  // second reference input power
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SECOND_REF_POWER_EN <= 1'b0;
    end
    else
    begin
      SECOND_REF_POWER_EN <= ricfg_bit(ref_cfg_reg,
                               `RICFG_BIT_SECOND_EN);
    end
  end

  // first reference input power
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      FIRST_REF_POWER_EN <= 1'b0;
    end
    else
    begin
      FIRST_REF_POWER_EN <= ricfg_bit(ref_cfg_reg,
                              `RICFG_BIT_FIRST_EN);
    end
  end

  // reference mode
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DIFF_MODE <= 1'b0;
    end
    else
    begin
      DIFF_MODE <= ricfg_bit(ref_cfg_reg, `RICFG_BIT_DIFF);
    end
  end

  // status pin; a source change shows one clock later
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      STATUS_PIN <= 1'b0;
    end
    else
    begin
      STATUS_PIN <= ricfg_status_pick(
                      aux_cfg_reg[`RICFG_BIT_EEPROM_OVR],
                      EEPROM_STATUS, STATUS_SOURCES,
                      sel_field);
    end
  end

endmodule // ricfg_top

// File: tb/ricfg_src_model.sv
/* status sources; free-running pattern, synchronous to CLK */
`timescale 1ns/1ps
module ricfg_src_model(input wire CLK, output reg EEPROM_STATUS = 0,
  output reg [63:0] STATUS_SOURCES = 64'h0);
  // status toggles every cycle; the 64 sources shift as a Johnson pattern, one bit changing per cycle
  always @(posedge CLK)
  begin
    EEPROM_STATUS <= ~EEPROM_STATUS;
    STATUS_SOURCES <= {STATUS_SOURCES[62:0], ~STATUS_SOURCES[63]};
  end
endmodule // ricfg_src_model

// File: tb/ricfg_checker.sv
/* assertions on ricfg_top ports; bound to every ricfg_top */
`timescale 1ns/1ps
module ricfg_checker(input wire CLK, RST_N, HSEL, HWRITE, HREADY,
  EEPROM_STATUS, FIRST_REF_POWER_EN, SECOND_REF_POWER_EN, DIFF_MODE,
  STATUS_PIN, HREADYOUT, HRESP,
  input wire [31:0] HADDR, HWDATA, input wire [1:0] HTRANS,
  input wire [63:0] STATUS_SOURCES);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire tk = HSEL & HREADY & HTRANS[1] & HWRITE;
  wire rc = tk && HADDR[11:2] == 10'h01c;
  reg [9:0] wi;
  reg       ov;
  reg [5:0] sl;
  // shadow of override bit and select field
  always @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      wi <= 10'h0; ov <= 1'b1; sl <= 6'h0;
    end
    else
    begin
      wi <= tk ? HADDR[11:2] : 10'h0;
      if (wi == 10'h01d) ov <= HWDATA[7];
      if (wi == 10'h017) sl <= HWDATA[7:2];
    end
  a_second_power: assert property (rc |-> ##3
    SECOND_REF_POWER_EN == $past(HWDATA[2], 2)) else $error("second enable");
  a_first_power: assert property (rc |-> ##3
    FIRST_REF_POWER_EN == $past(HWDATA[1], 2)) else $error("first enable");
  a_diff_mode: assert property (rc |-> ##3
    DIFF_MODE == $past(HWDATA[0], 2)) else $error("diff mode");
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus response");
  a_status_select: assert property (!ov |=>
    STATUS_PIN == $past(STATUS_SOURCES[sl])) else $error("status sel");
  a_status_override: assert property (ov |=>
    STATUS_PIN == $past(EEPROM_STATUS)) else $error("status ovr");
endmodule // ricfg_checker
bind ricfg_top ricfg_checker chk_u(.*);

// File: tb/tb_ref_input_and_status_pin_config.sv
/* bench for ricfg_top; AHB-Lite master tasks, source model */
`timescale 1ns/1ps
module tb_ref_input_and_status_pin_config;
  reg CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0;
  reg [1:0] HTRANS = 0;
  reg [31:0] HADDR = 0, HWDATA = 0;
  wire [31:0] HRDATA;
  wire [63:0] STATUS_SOURCES;
  wire HREADYOUT, HRESP, FIRST_REF_POWER_EN, SECOND_REF_POWER_EN, DIFF_MODE,
    STATUS_PIN, EEPROM_STATUS;
  integer fails = 0, n_checks = 0, cyc = 0, i;
  always #2.5 CLK = ~CLK;
  ricfg_src_model src_u(.CLK, .EEPROM_STATUS, .STATUS_SOURCES);
  ricfg_top dut_u(.CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .EEPROM_STATUS,
    .STATUS_SOURCES, .HRDATA, .HREADYOUT, .HRESP, .FIRST_REF_POWER_EN,
    .SECOND_REF_POWER_EN, .DIFF_MODE, .STATUS_PIN);
  task summarize;
  begin
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  end
  endtask
  task ck(input [31:0] g, e);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task xf(input w, input [31:0] a, d);
  begin
    HSEL <= 1; HTRANS <= 2'h2; HWRITE <= w; HADDR <= a;
    @(posedge CLK); while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 0; HTRANS <= 2'h0; HWDATA <= w ? d : 32'h0;
    @(posedge CLK); while (HREADYOUT !== 1'b1) @(posedge CLK);
    if (!w) ck(HRDATA, d);
  end
  endtask
  task outs(input [2:0] e);
  begin
    repeat (2) @(posedge CLK);
    ck({SECOND_REF_POWER_EN, FIRST_REF_POWER_EN, DIFF_MODE}, e);
    ck({HRESP, HREADYOUT}, 2'b01);
  end
  endtask
  // expected pin level from the sources seen one edge earlier
  task stat(input o, input [5:0] s);
  reg e;
  begin
    @(posedge CLK);
    e = o ? EEPROM_STATUS : STATUS_SOURCES[s];
    @(posedge CLK);
    ck(STATUS_PIN, e);
  end
  endtask
  always @(posedge CLK)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      fails = fails + 1;
      summarize;
    end
  end
  initial
  begin
    repeat (16) @(posedge CLK);
    RST_N <= 1;
    @(posedge CLK);
    xf(0, 32'h70, 32'h0);
    xf(0, 32'h74, 32'h80);
    xf(0, 32'h5c, 32'h0);
    outs(3'b000);
    stat(1, 6'h00);
    $display("reset test done");
    xf(1, 32'h70, 32'he6);
    xf(0, 32'h70, 32'he6);
    outs(3'b110);
    xf(1, 32'h70, 32'h0);
    xf(1, 32'h70, 32'h1);
    xf(0, 32'h70, 32'h1);
    outs(3'b001);
    $display("reference test done");
    xf(1, 32'h74, 32'h0);
    for (i = 0; i < 64; i = i + 9)
    begin
      xf(1, 32'h5c, i << 2);
      stat(0, i);
    end
    xf(1, 32'h74, 32'h80);
    stat(1, 6'h00);
    xf(1, 32'h0, 32'hff);
    xf(0, 32'h0, 32'h0);
    $display("status test done");
    summarize;
  end
endmodule // tb_ref_input_and_status_pin_config
